/* include/sensor_comp_pkg.sv */
package sensor_comp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int NV_BYTES      = 48;
  localparam int ADR_W         = 9;
  localparam int CODE_W        = 10;
  localparam int COEF_W        = 12;
  localparam int SIG_FRAC_BITS = 10;
  localparam int TC_FRAC_BITS  = 8;

  // ----------------------------------------------------------------
  // nonvolatile image: byte positions
  // ----------------------------------------------------------------
  localparam int NV_COARSE     = 2;
  localparam int NV_GAIN_LO    = 3;
  localparam int NV_OFFS_LO    = 4;
  localparam int NV_GAP_COUNT  = 5;
  localparam int NV_TEMP_BP    = 6;   // temp breakpoints one..three, 6..8
  localparam int NV_SIG_BP     = 9;   // signal breakpoints 2..5, high then low, 9..16
  localparam int NV_TRIM_HI    = 17;
  localparam int NV_ORDINATE   = 18;  // one ordinate per signal range, 18..22
  localparam int NV_ALM_LO_TRG = 27;
  localparam int NV_ALM_LO_OUT = 28;
  localparam int NV_ALM_HI_TRG = 29;
  localparam int NV_ALM_HI_OUT = 30;
  localparam int NV_SRC_CTRL   = 31;
  localparam int NV_STEER_LVL  = 28;  // three transition levels, 28..30
  localparam int NV_GAIN_TC    = 32;  // low then high byte per gap, 32..39
  localparam int NV_OFFS_TC    = 40;  // 40..47
  localparam int NV_SIG_TC     = 38;  // signal coefficients share the table, 38..47

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GAIN_HI_LSB   = 0;
  localparam int OFFS_HI_LSB   = 2;
  localparam int CGAIN_LSB     = 0;
  localparam int CGAIN_W       = 3;
  localparam int COFFS_LSB     = 4;
  localparam int COFFS_W       = 4;
  localparam int MODE_DIGITAL  = 6;
  localparam int MODE_ALARM    = 5;
  localparam int MODE_STEER    = 4;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] REG_MODE       = 9'h000;
  localparam logic [ADR_W-1:0] REG_STATUS     = 9'h004;
  localparam logic [ADR_W-1:0] REG_GAIN_DAC   = 9'h008;
  localparam logic [ADR_W-1:0] REG_OFFSET_DAC = 9'h00C;
  localparam logic [ADR_W-1:0] REG_SIGNAL_OUT = 9'h010;
  localparam logic [ADR_W-1:0] REG_NV_BASE    = 9'h100;
  localparam logic [7:0]       MODE_RESET     = 8'h00;
  localparam logic [7:0]       NV_RESET       = 8'h00;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_GAIN_STAGE = 4'b0000,
    SRC_TEMP       = 4'b0010,
    SRC_VOUT       = 4'b0011,
    SRC_AUX_ONE    = 4'b0100,
    SRC_AUX_TWO    = 4'b0101,
    SRC_AMP        = 4'b0110
  } src_sel_t;

  localparam logic [3:0] SRANGE_FIXED = 4'hF;
  localparam logic [3:0] SRANGE_1     = 4'hE;
  localparam logic [3:0] SRANGE_2     = 4'hC;
  localparam logic [3:0] SRANGE_3     = 4'hA;
  localparam logic [3:0] SRANGE_4     = 4'h8;
  localparam logic [3:0] SRANGE_5     = 4'h6;
  localparam logic [3:0] TGAP_FIXED   = 4'h0;
  localparam logic [3:0] TGAP_2       = 4'h5;
  localparam logic [3:0] TGAP_3       = 4'h8;
  localparam logic [3:0] TGAP_4       = 4'hB;

endpackage : sensor_comp_pkg

/* logic/sensor_compensation_calc.sv */
`timescale 1ns/1ps

// Functional notes
// - after reset, gain and offset DAC codes are recomputed continuously for one to four gaps
// - first gap: gain equals trim minus coefficient one times (breakpoint one minus temp)
// - later gaps chain: previous result plus coefficient times excess over prior breakpoint
// - gain trim is ten bits built from byte 3 and part of byte 17
// - offset trim is ten bits built from byte 4 and part of byte 17
// - offset code uses the same piecewise chaining with offset trim and coefficients
// - coarse gain and coarse offset selections come from fields of byte 2
// - each temperature coefficient is a low byte and a high byte of the table
// - digital output is (signal minus range breakpoint) times coefficient plus ordinate
// - signal coefficients are twelve bits: sign, one integer bit, ten fraction bits
// - signal breakpoints are ten bits, stored high byte first then low byte
// - upper nibble of gap-count byte selects number of signal ranges
// - lower nibble of gap-count byte selects number of temperature gaps
// - shared storage caps signal ranges by temperature gaps: 5, 3, 2, fixed
// - alarm uses five bytes; output clamps to programmed level past a trigger
// - alarm levels are eight bits compared to upper eight of ten signal bits
// - alarm source is upper nibble of byte 31 with six source codes
// - level steering drives both aux pins from eight-bit levels of selected signal
// - level steering masks the alarm enable; alarm flags can last into the first steering cycle
// - steering uses control byte and three levels; four source codes
// - mode bit 6 digital, bit 5 alarm enable, bit 4 level steering
// - filtered temperature is ten bits left-justified in a sixteen-bit field
module sensor_compensation_calc #(
  parameter int TC_FRAC = sensor_comp_pkg::TC_FRAC_BITS
) (
  // clock and reset
  input  wire logic                                   MCLK_IN,
  input  wire logic                                   RST_B_IN,
  // wishbone slave
  input  wire logic                                   WB_CYC_IN,
  input  wire logic                                   WB_STB_IN,
  input  wire logic                                   WB_WE_IN,
  input  wire logic [sensor_comp_pkg::ADR_W-1:0]      WB_ADR_IN,
  input  wire logic [3:0]                             WB_SEL_IN,
  input  wire logic [31:0]                            WB_DAT_IN,
  output logic      [31:0]                            WB_DAT_OUT,
  output logic                                        WB_ACK_OUT,
  // measurements from the converter datapath
  input  wire logic [15:0]                            FILT_TEMP_IN,
  input  wire logic [sensor_comp_pkg::CODE_W-1:0]     TEMPERATURE_SIGNAL_IN,
  input  wire logic [sensor_comp_pkg::CODE_W-1:0]     AMPLIFIER_SIGNAL_IN,
  input  wire logic [sensor_comp_pkg::CODE_W-1:0]     GAIN_STAGE_SIGNAL_IN,
  input  wire logic [sensor_comp_pkg::CODE_W-1:0]     VOLTAGE_OUTPUT_SIGNAL_IN,
  input  wire logic [sensor_comp_pkg::CODE_W-1:0]     AUX_PIN_ONE_LEVEL_IN,
  input  wire logic [sensor_comp_pkg::CODE_W-1:0]     AUX_PIN_TWO_LEVEL_IN,
  // dac settings
  output logic      [sensor_comp_pkg::CODE_W-1:0]     GAIN_DAC_OUT,
  output logic      [sensor_comp_pkg::CODE_W-1:0]     OFFSET_DAC_OUT,
  output logic      [sensor_comp_pkg::CGAIN_W-1:0]    COARSE_GAIN_SEL_OUT,
  output logic      [sensor_comp_pkg::COFFS_W-1:0]    COARSE_OFFSET_SEL_OUT,
  // digital path
  output logic                                        DIGITAL_MODE_OUT,
  output logic      [sensor_comp_pkg::CODE_W-1:0]     SIGNAL_OUT,
  output logic                                        ALARM_LOW_OUT,
  output logic                                        ALARM_HIGH_OUT,
  // aux pins
  output logic                                        AUX_PIN_ONE_OUT,
  output logic                                        AUX_PIN_ONE_OE_OUT,
  output logic                                        AUX_PIN_TWO_OUT,
  output logic                                        AUX_PIN_TWO_OE_OUT
);

  localparam int CW = sensor_comp_pkg::CODE_W;
  localparam int NB = sensor_comp_pkg::NV_BYTES;

  if (TC_FRAC < 0 || TC_FRAC > 11) begin : g_bad_frac
    $error("TC_FRAC must lie in 0..11");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NB-1:0][7:0] nv;
    logic [7:0]         mode;
    logic               ack;
    logic [31:0]        rdata;
    logic [CW-1:0]      gain;
    logic [CW-1:0]      offs;
    logic [CW-1:0]      sig_out;
    logic               alm_lo;
    logic               alm_hi;
    logic [1:0]         steer;
  } state_t;

  state_t st_q;
  state_t st_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic signed [11:0] coef12(input logic [7:0] lo, input logic [7:0] hi);
    coef12 = $signed({hi[3:0], lo});  // values above 2047 read as negative
  endfunction : coef12

  function automatic logic signed [10:0] diff11(input logic [CW-1:0] a, input logic [CW-1:0] b);
    diff11 = $signed({1'b0, a}) - $signed({1'b0, b});
  endfunction : diff11

  function automatic logic [CW-1:0] clamp10(input logic signed [17:0] v);
    if (v < 18'sd0) begin
      clamp10 = '0;
    end else if (v > 18'sd1023) begin
      clamp10 = 10'h3FF;
    end else begin
      clamp10 = v[CW-1:0];
    end
  endfunction : clamp10

  function automatic logic signed [17:0] tc_term(input logic signed [11:0] c, input logic signed [10:0] d);
    logic signed [22:0] p;
    p       = c * d;
    tc_term = 18'(p >>> TC_FRAC);
  endfunction : tc_term

  // piecewise chain over temperature gaps; bp holds breakpoints one..three
  function automatic logic [CW-1:0] temp_setting(input logic [CW-1:0]       trim,
                                                 input logic [3:0][15:0]    cf,
                                                 input logic [CW-1:0]       t,
                                                 input logic [2:0][CW-1:0]  bp,
                                                 input logic [2:0]          ngaps);
    logic signed [17:0] acc;
    logic [CW-1:0]      upper;
    acc   = $signed({8'h00, trim});
    upper = '0;
    if (ngaps <= 3'd1 || t < bp[0]) begin
      acc = acc - tc_term(coef12(cf[0][7:0], cf[0][15:8]), diff11(bp[0], t));
    end else begin
      for (int k = 1; k < 4; k++) begin
        if (k < int'(ngaps) && t >= bp[k-1]) begin
          upper = (k + 1 < int'(ngaps) && k < 3 && t >= bp[k % 3]) ? bp[k % 3] : t;
          acc   = acc + tc_term(coef12(cf[k][7:0], cf[k][15:8]), diff11(upper, bp[k-1]));
        end
      end
    end
    temp_setting = clamp10(acc);
  endfunction : temp_setting

  function automatic logic [CW-1:0] pick_src(input logic [3:0] code, input logic allow_aux);
    case (code)
      sensor_comp_pkg::SRC_TEMP:    pick_src = TEMPERATURE_SIGNAL_IN;
      sensor_comp_pkg::SRC_AMP:     pick_src = AMPLIFIER_SIGNAL_IN;
      sensor_comp_pkg::SRC_VOUT:    pick_src = VOLTAGE_OUTPUT_SIGNAL_IN;
      sensor_comp_pkg::SRC_AUX_ONE: pick_src = allow_aux ? AUX_PIN_ONE_LEVEL_IN : GAIN_STAGE_SIGNAL_IN;
      sensor_comp_pkg::SRC_AUX_TWO: pick_src = allow_aux ? AUX_PIN_TWO_LEVEL_IN : GAIN_STAGE_SIGNAL_IN;
      default:                      pick_src = GAIN_STAGE_SIGNAL_IN;
    endcase
  endfunction : pick_src

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic [CW-1:0]          temp_f;
  logic [CW-1:0]          gain_trim;
  logic [CW-1:0]          offset_trim;
  logic [7:0]             gap_count_byte;
  logic [2:0]             n_tgaps;
  logic [2:0]             n_srange_code;
  logic [2:0]             n_srange_cap;
  logic [2:0]             n_srange;
  logic [2:0][CW-1:0]     temp_bp;
  logic [3:0][15:0]       gain_temp_coef;
  logic [3:0][15:0]       offset_temp_coef;
  logic [4:0][CW-1:0]     signal_breakpoint;
  logic                   digital_en;
  logic                   alarm_en;
  logic                   steer_en;

  always_comb begin
    temp_f         = FILT_TEMP_IN[15:6];
    gain_trim      = {st_q.nv[sensor_comp_pkg::NV_TRIM_HI][sensor_comp_pkg::GAIN_HI_LSB +: 2],
                      st_q.nv[sensor_comp_pkg::NV_GAIN_LO]};
    offset_trim    = {st_q.nv[sensor_comp_pkg::NV_TRIM_HI][sensor_comp_pkg::OFFS_HI_LSB +: 2],
                      st_q.nv[sensor_comp_pkg::NV_OFFS_LO]};
    gap_count_byte = st_q.nv[sensor_comp_pkg::NV_GAP_COUNT];
    digital_en     = st_q.mode[sensor_comp_pkg::MODE_DIGITAL];
    steer_en       = st_q.mode[sensor_comp_pkg::MODE_STEER];
    alarm_en       = st_q.mode[sensor_comp_pkg::MODE_ALARM] & ~steer_en;
    case (gap_count_byte[3:0])
      sensor_comp_pkg::TGAP_2: n_tgaps = 3'd2;
      sensor_comp_pkg::TGAP_3: n_tgaps = 3'd3;
      sensor_comp_pkg::TGAP_4: n_tgaps = 3'd4;
      default:                 n_tgaps = 3'd1;
    endcase
    case (gap_count_byte[7:4])
      sensor_comp_pkg::SRANGE_1: n_srange_code = 3'd1;
      sensor_comp_pkg::SRANGE_2: n_srange_code = 3'd2;
      sensor_comp_pkg::SRANGE_3: n_srange_code = 3'd3;
      sensor_comp_pkg::SRANGE_4: n_srange_code = 3'd4;
      sensor_comp_pkg::SRANGE_5: n_srange_code = 3'd5;
      default:                   n_srange_code = 3'd0;
    endcase
    case (n_tgaps)
      3'd2:    n_srange_cap = 3'd3;
      3'd3:    n_srange_cap = 3'd2;
      3'd4:    n_srange_cap = 3'd0;
      default: n_srange_cap = 3'd5;
    endcase
    n_srange = (n_srange_code < n_srange_cap) ? n_srange_code : n_srange_cap;
    for (int k = 0; k < 3; k++) begin
      temp_bp[k] = {st_q.nv[sensor_comp_pkg::NV_TEMP_BP + k], 2'b00};
    end
    for (int k = 0; k < 4; k++) begin
      gain_temp_coef[k]   = {st_q.nv[sensor_comp_pkg::NV_GAIN_TC + 2*k + 1],
                             st_q.nv[sensor_comp_pkg::NV_GAIN_TC + 2*k]};
      offset_temp_coef[k] = {st_q.nv[sensor_comp_pkg::NV_OFFS_TC + 2*k + 1],
                             st_q.nv[sensor_comp_pkg::NV_OFFS_TC + 2*k]};
    end
    signal_breakpoint[0] = '0;
    for (int k = 1; k < 5; k++) begin
      signal_breakpoint[k] = {st_q.nv[sensor_comp_pkg::NV_SIG_BP + 2*(k-1)][1:0],
                              st_q.nv[sensor_comp_pkg::NV_SIG_BP + 2*(k-1) + 1]};
    end
  end

  // ----------------------------------------------------------------
  // signal correction, alarm and steering
  // ----------------------------------------------------------------
  logic [2:0]            range_idx;
  logic signed [11:0]    sig_coef;
  logic signed [22:0]    sig_prod;
  logic [CW-1:0]         corrected;
  logic [CW-1:0]         alarm_src;
  logic [CW-1:0]         steer_src;
  logic [7:0]            src_top;
  logic [7:0]            steer_top;
  logic [1:0]            steer_cnt;

  always_comb begin
    range_idx = '0;
    for (int k = 1; k < 5; k++) begin
      if (k < int'(n_srange) && GAIN_STAGE_SIGNAL_IN >= signal_breakpoint[k]) begin
        range_idx = 3'(k);
      end
    end
    sig_coef = coef12(st_q.nv[sensor_comp_pkg::NV_SIG_TC + 2*range_idx],
                      st_q.nv[sensor_comp_pkg::NV_SIG_TC + 2*range_idx + 1]);
    sig_prod = sig_coef * diff11(GAIN_STAGE_SIGNAL_IN, signal_breakpoint[range_idx]);
    if (!digital_en || n_srange == 3'd0) begin
      corrected = GAIN_STAGE_SIGNAL_IN;
    end else begin
      corrected = clamp10(18'(sig_prod >>> sensor_comp_pkg::SIG_FRAC_BITS)
                          + $signed({8'h00, st_q.nv[sensor_comp_pkg::NV_ORDINATE + range_idx], 2'b00}));
    end
    alarm_src = pick_src(st_q.nv[sensor_comp_pkg::NV_SRC_CTRL][7:4], 1'b1);
    steer_src = pick_src(st_q.nv[sensor_comp_pkg::NV_SRC_CTRL][7:4], 1'b0);
    src_top   = alarm_src[CW-1:2];
    steer_top = steer_src[CW-1:2];
    steer_cnt = '0;
    for (int k = 0; k < 3; k++) begin
      if (steer_top >= st_q.nv[sensor_comp_pkg::NV_STEER_LVL + k]) begin
        steer_cnt = steer_cnt + 2'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic          bus_req;
  logic [5:0]    nv_idx;
  logic          nv_hit;

  always_comb begin
    st_d    = st_q;
    bus_req = WB_CYC_IN & WB_STB_IN & ~st_q.ack;
    nv_idx  = WB_ADR_IN[7:2];
    nv_hit  = WB_ADR_IN[8] && (WB_ADR_IN[1:0] == 2'b00) && (int'(nv_idx) < NB);

    // dac settings, recomputed every cycle
    st_d.gain = temp_setting(gain_trim, gain_temp_coef, temp_f, temp_bp, n_tgaps);
    st_d.offs = temp_setting(offset_trim, offset_temp_coef, temp_f, temp_bp, n_tgaps);

    // alarm clamps the output, otherwise the corrected value passes
    st_d.sig_out = corrected;
    st_d.alm_lo  = 1'b0;
    st_d.alm_hi  = 1'b0;
    if (alarm_en) begin
      if (src_top < st_q.nv[sensor_comp_pkg::NV_ALM_LO_TRG]) begin
        st_d.sig_out = {st_q.nv[sensor_comp_pkg::NV_ALM_LO_OUT], 2'b00};
        st_d.alm_lo  = 1'b1;
      end else if (src_top > st_q.nv[sensor_comp_pkg::NV_ALM_HI_TRG]) begin
        st_d.sig_out = {st_q.nv[sensor_comp_pkg::NV_ALM_HI_OUT], 2'b00};
        st_d.alm_hi  = 1'b1;
      end
    end
    st_d.steer = steer_en ? steer_cnt : 2'b00;

    // bus: one wait state, ack drops the cycle after it is given
    st_d.ack   = bus_req;
    st_d.rdata = '0;
    if (bus_req && WB_WE_IN && WB_SEL_IN[0]) begin
      if (WB_ADR_IN == sensor_comp_pkg::REG_MODE) begin
        st_d.mode = WB_DAT_IN[7:0];
      end else if (nv_hit) begin
        st_d.nv[nv_idx] = WB_DAT_IN[7:0];
      end
    end
    if (bus_req && !WB_WE_IN) begin
      case (WB_ADR_IN)
        sensor_comp_pkg::REG_MODE:       st_d.rdata = {24'h000000, st_q.mode};
        sensor_comp_pkg::REG_STATUS:     st_d.rdata = {28'h0000000, st_q.steer, st_q.alm_hi, st_q.alm_lo};
        sensor_comp_pkg::REG_GAIN_DAC:   st_d.rdata = {22'h000000, st_q.gain};
        sensor_comp_pkg::REG_OFFSET_DAC: st_d.rdata = {22'h000000, st_q.offs};
        sensor_comp_pkg::REG_SIGNAL_OUT: st_d.rdata = {22'h000000, st_q.sig_out};
        default:                         st_d.rdata = nv_hit ? {24'h000000, st_q.nv[nv_idx]} : 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st_q      <= '0;
      st_q.mode <= sensor_comp_pkg::MODE_RESET;
      st_q.nv   <= {NB{sensor_comp_pkg::NV_RESET}};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    WB_ACK_OUT            = st_q.ack;
    WB_DAT_OUT            = st_q.rdata;
    GAIN_DAC_OUT          = st_q.gain;
    OFFSET_DAC_OUT        = st_q.offs;
    COARSE_GAIN_SEL_OUT   = st_q.nv[sensor_comp_pkg::NV_COARSE]
                            [sensor_comp_pkg::CGAIN_LSB +: sensor_comp_pkg::CGAIN_W];
    COARSE_OFFSET_SEL_OUT = st_q.nv[sensor_comp_pkg::NV_COARSE]
                            [sensor_comp_pkg::COFFS_LSB +: sensor_comp_pkg::COFFS_W];
    DIGITAL_MODE_OUT      = st_q.mode[sensor_comp_pkg::MODE_DIGITAL];
    SIGNAL_OUT            = st_q.sig_out;
    ALARM_LOW_OUT         = st_q.alm_lo;
    ALARM_HIGH_OUT        = st_q.alm_hi;
    AUX_PIN_ONE_OUT       = st_q.steer[0];
    AUX_PIN_TWO_OUT       = st_q.steer[1];
    // pins stay inputs unless steering owns them
    AUX_PIN_ONE_OE_OUT    = st_q.mode[sensor_comp_pkg::MODE_STEER];
    AUX_PIN_TWO_OE_OUT    = st_q.mode[sensor_comp_pkg::MODE_STEER];
  end

endmodule : sensor_compensation_calc

/* verif/sensor_compensation_calc_props.sv */
`timescale 1ns/1ps
module sensor_comp_props (
  input wire logic       MCLK_IN, RST_B_IN, WB_CYC_IN, WB_STB_IN, WB_WE_IN, WB_ACK_OUT,
  input wire logic [9:0] GAIN_STAGE_SIGNAL_IN, SIGNAL_OUT,
  input wire logic [2:0] COARSE_GAIN_SEL_OUT,
  input wire logic [3:0] COARSE_OFFSET_SEL_OUT,
  input wire logic       DIGITAL_MODE_OUT, ALARM_LOW_OUT, ALARM_HIGH_OUT, AUX_PIN_ONE_OE_OUT, AUX_PIN_TWO_OE_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_B_IN);
  wire alm = ALARM_LOW_OUT | ALARM_HIGH_OUT;
  ack_one_beat_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack held too long");
  ack_answers_req_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("request not answered");
  ack_has_cause_a: assert property (WB_ACK_OUT |-> $past(WB_CYC_IN) && $past(WB_STB_IN)) else $error("stray ack");
  pins_enable_pair_a: assert property (AUX_PIN_ONE_OE_OUT == AUX_PIN_TWO_OE_OUT) else $error("oe split");
  steer_alarm_excl_a: assert property (AUX_PIN_ONE_OE_OUT && $past(AUX_PIN_ONE_OE_OUT) |-> !alm)
    else $error("alarm while steering");
  alarm_one_side_a: assert property (!(ALARM_LOW_OUT && ALARM_HIGH_OUT)) else $error("both alarms");
  analog_pass_a: assert property ($past(RST_B_IN) && !DIGITAL_MODE_OUT && !$past(DIGITAL_MODE_OUT) && !alm
    |-> SIGNAL_OUT == $past(GAIN_STAGE_SIGNAL_IN)) else $error("analog output altered");
  coarse_from_write_a: assert property ($past(RST_B_IN) &&
    ($changed(COARSE_GAIN_SEL_OUT) || $changed(COARSE_OFFSET_SEL_OUT)) |->
    (WB_ACK_OUT && WB_WE_IN) || ($past(WB_ACK_OUT) && $past(WB_WE_IN))) else $error("coarse changed alone");
  cover property (ALARM_LOW_OUT);
  cover property (ALARM_HIGH_OUT);
  cover property (ALARM_HIGH_OUT ##1 AUX_PIN_ONE_OE_OUT);
endmodule : sensor_comp_props

bind sensor_compensation_calc sensor_comp_props u_props (.MCLK_IN, .RST_B_IN, .WB_CYC_IN, .WB_STB_IN,
  .WB_WE_IN, .WB_ACK_OUT, .GAIN_STAGE_SIGNAL_IN, .SIGNAL_OUT, .COARSE_GAIN_SEL_OUT, .COARSE_OFFSET_SEL_OUT,
  .DIGITAL_MODE_OUT, .ALARM_LOW_OUT, .ALARM_HIGH_OUT, .AUX_PIN_ONE_OE_OUT, .AUX_PIN_TWO_OE_OUT);

/* verif/sensor_compensation_calc_tb.sv */
`timescale 1ns/1ps
module sensor_compensation_calc_tb;
  logic MCLK_IN = 0, RST_B_IN = 0, WB_CYC_IN = 0, WB_STB_IN = 0, WB_WE_IN = 0, WB_ACK_OUT, DIGITAL_MODE_OUT;
  logic ALARM_LOW_OUT, ALARM_HIGH_OUT, AUX_PIN_ONE_OUT, AUX_PIN_ONE_OE_OUT, AUX_PIN_TWO_OUT, AUX_PIN_TWO_OE_OUT;
  logic [8:0] WB_ADR_IN = 9'h000;
  logic [3:0] WB_SEL_IN = 4'hF, sel = 4'h0, COARSE_OFFSET_SEL_OUT;
  logic [2:0] COARSE_GAIN_SEL_OUT;
  logic [31:0] WB_DAT_IN = 32'h0, WB_DAT_OUT;
  logic [15:0] FILT_TEMP_IN;
  logic [9:0] TEMPERATURE_SIGNAL_IN, AMPLIFIER_SIGNAL_IN, GAIN_STAGE_SIGNAL_IN, VOLTAGE_OUTPUT_SIGNAL_IN;
  logic [9:0] AUX_PIN_ONE_LEVEL_IN, AUX_PIN_TWO_LEVEL_IN, GAIN_DAC_OUT, OFFSET_DAC_OUT, SIGNAL_OUT;
  logic [9:0] sig = 10'h000, tcode = 10'h000;
  int n_mismatch = 0, check_count = 0, seed = 32'h3EF2, i;
  logic [31:0] expq[$];
  logic [7:0] gt[3] = '{8'h00, 8'h00, 8'h05}, lo[3] = '{8'h10, 8'hF0, 8'h20}, hi[3] = '{8'h00, 8'h0F, 8'h00};
  logic [9:0] tt[3] = '{10'h100, 10'h100, 10'h280}, ge[3] = '{10'h295, 10'h2B5, 10'h2B5};
  logic [7:0] dg[4] = '{8'hE0, 8'hE0, 8'hF0, 8'hEB}, dh[4] = '{8'h04, 8'h0C, 8'h04, 8'h04};
  logic [9:0] de[4] = '{10'h060, 10'h020, 10'h020, 10'h020}, sv[4] = '{10'h000, 10'h100, 10'h340, 10'h3FC};
  logic [3:0] sc[6] = '{4'h2, 4'h6, 4'h0, 4'h3, 4'h4, 4'h5};
  always #4 MCLK_IN = ~MCLK_IN;
  sensor_compensation_calc uut (.MCLK_IN, .RST_B_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN,
    .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT, .FILT_TEMP_IN, .TEMPERATURE_SIGNAL_IN, .AMPLIFIER_SIGNAL_IN,
    .GAIN_STAGE_SIGNAL_IN, .VOLTAGE_OUTPUT_SIGNAL_IN, .AUX_PIN_ONE_LEVEL_IN, .AUX_PIN_TWO_LEVEL_IN, .GAIN_DAC_OUT,
    .OFFSET_DAC_OUT, .COARSE_GAIN_SEL_OUT, .COARSE_OFFSET_SEL_OUT, .DIGITAL_MODE_OUT, .SIGNAL_OUT, .ALARM_LOW_OUT,
    .ALARM_HIGH_OUT, .AUX_PIN_ONE_OUT, .AUX_PIN_ONE_OE_OUT, .AUX_PIN_TWO_OUT, .AUX_PIN_TWO_OE_OUT);
  sensor_front_end_model fe (.clk_in(MCLK_IN), .sig_in(sig), .tcode_in(tcode), .sel_in(sel),
    .filt_temp_out(FILT_TEMP_IN), .temp_out(TEMPERATURE_SIGNAL_IN), .amp_out(AMPLIFIER_SIGNAL_IN),
    .gain_out(GAIN_STAGE_SIGNAL_IN), .vout_out(VOLTAGE_OUTPUT_SIGNAL_IN), .aux1_out(AUX_PIN_ONE_LEVEL_IN),
    .aux2_out(AUX_PIN_TWO_LEVEL_IN));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // holds the request until ack is sampled; the loop bound cuts a hang short
  task automatic wb(input logic we, input logic [8:0] a, input logic [7:0] d);
    int n;
    @(posedge MCLK_IN);
    WB_CYC_IN <= 1'b1; WB_STB_IN <= 1'b1; WB_WE_IN <= we; WB_ADR_IN <= a; WB_DAT_IN <= {24'h0, d};
    for (n = 0; n < 20 && WB_ACK_OUT !== 1'b1; n++) @(posedge MCLK_IN);
    if (n == 20) begin n_mismatch++; stop_test(); end
    WB_CYC_IN <= 1'b0; WB_STB_IN <= 1'b0;
  endtask : wb
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    expq.push_back(e);
    wb(1'b0, a, 8'h00);
  endtask : rd
  function automatic logic [8:0] nv(input int n);
    return 9'h100 + 9'(4 * n);
  endfunction : nv
  task automatic settle;
    repeat (2) @(negedge MCLK_IN);
  endtask : settle
  // an ack with nothing queued compares against a value no read can return
  always @(posedge MCLK_IN) if (WB_ACK_OUT === 1'b1 && WB_WE_IN === 1'b0) begin
    check(WB_DAT_OUT, expq.size() > 0 ? expq.pop_front() : 32'hFFFFFFFF);
  end
  initial begin
    repeat (10) @(posedge MCLK_IN);
    RST_B_IN <= 1'b1;
    rd(sensor_comp_pkg::REG_MODE, 32'h0);
    wb(1'b1, 9'h0F0, 8'h77);
    rd(9'h0F0, 32'h0);
    wb(1'b1, sensor_comp_pkg::REG_GAIN_DAC, 8'h55);
    rd(sensor_comp_pkg::REG_GAIN_DAC, 32'h0);
    $display("reset and refused access test done");
    wb(1'b1, nv(3), 8'hA5); wb(1'b1, nv(4), 8'h3C); wb(1'b1, nv(17), 8'h06);
    wb(1'b1, nv(6), 8'h80); wb(1'b1, nv(7), 8'hFF); wb(1'b1, nv(8), 8'hFF);
    for (i = 0; i < 3; i++) begin
      tcode <= tt[i];
      wb(1'b1, nv(5), gt[i]); wb(1'b1, nv(32 + 2 * (i / 2)), lo[i]); wb(1'b1, nv(33 + 2 * (i / 2)), hi[i]);
      rd(sensor_comp_pkg::REG_GAIN_DAC, {22'h0, ge[i]});
      rd(sensor_comp_pkg::REG_OFFSET_DAC, 32'h13C);
      check(32'(GAIN_DAC_OUT), 32'(ge[i]));
      check(32'(OFFSET_DAC_OUT), 32'h13C);
    end
    wb(1'b1, nv(2), 8'h5A);
    settle();
    check(32'(COARSE_GAIN_SEL_OUT), 32'h2);
    check(32'(COARSE_OFFSET_SEL_OUT), 32'h5);
    $display("temperature gap test done");
    wb(1'b1, sensor_comp_pkg::REG_MODE, 8'h40); wb(1'b1, nv(18), 8'h10); wb(1'b1, nv(38), 8'h00);
    sig <= 10'h020;
    for (i = 0; i < 4; i++) begin
      wb(1'b1, nv(5), dg[i]); wb(1'b1, nv(39), dh[i]);
      rd(sensor_comp_pkg::REG_SIGNAL_OUT, {22'h0, de[i]});
    end
    wb(1'b1, nv(5), 8'hC0); wb(1'b1, nv(10), 8'h80); wb(1'b1, nv(41), 8'h04); sig <= 10'h0A0;
    rd(sensor_comp_pkg::REG_SIGNAL_OUT, 32'h020);
    check(32'(DIGITAL_MODE_OUT), 32'h1);
    $display("signal correction test done");
    // alarm bytes stay zero until the alarm is in use
    wb(1'b1, sensor_comp_pkg::REG_MODE, 8'h20); wb(1'b1, nv(27), 8'h40); wb(1'b1, nv(28), 8'h11);
    wb(1'b1, nv(29), 8'hC0); wb(1'b1, nv(30), 8'hEE);
    for (i = 0; i < 6; i++) begin
      wb(1'b1, nv(31), {sc[i], 4'h0});
      sel <= sc[i];
      sig <= i[0] ? 10'h3F0 : {2'b00, 8'($random(seed))};
      settle();
      check({22'h0, SIGNAL_OUT}, i[0] ? 32'h3B8 : 32'h044);
      check({30'h0, ALARM_HIGH_OUT, ALARM_LOW_OUT}, i[0] ? 32'h2 : 32'h1);
    end
    $display("alarm test done");
    wb(1'b1, sensor_comp_pkg::REG_MODE, 8'h30); wb(1'b1, nv(31), 8'h20);
    sel <= 4'h2;
    for (i = 0; i < 4; i++) begin
      @(posedge MCLK_IN);
      sig <= sv[i];
      settle();
      check({26'h0, AUX_PIN_TWO_OE_OUT, AUX_PIN_ONE_OE_OUT, AUX_PIN_TWO_OUT, AUX_PIN_ONE_OUT, ALARM_LOW_OUT,
        ALARM_HIGH_OUT}, {26'h0, 2'b11, 2'(i), 2'b00});
    end
    $display("level steering test done");
    stop_test();
  end
endmodule : sensor_compensation_calc_tb

/* verif/sensor_front_end_model.sv */
`timescale 1ns/1ps
module sensor_front_end_model (
  input  wire logic       clk_in,
  input  wire logic [9:0] sig_in, tcode_in,
  input  wire logic [3:0] sel_in,
  output logic [15:0]     filt_temp_out,
  output logic [9:0]      temp_out, amp_out, gain_out, vout_out, aux1_out, aux2_out
);
  logic [5:0] noise_q = 6'h2A;
  always @(posedge clk_in) noise_q <= noise_q + 6'h1;
  // unused low bits churn so nothing can count them as zero
  assign filt_temp_out = {tcode_in, noise_q};
  // only the named source carries the stimulus; every other shows its inverse
  assign temp_out = (sel_in == 4'h2) ? sig_in : ~sig_in;
  assign amp_out  = (sel_in == 4'h6) ? sig_in : ~sig_in;
  assign gain_out = (sel_in == 4'h0) ? sig_in : ~sig_in;
  assign vout_out = (sel_in == 4'h3) ? sig_in : ~sig_in;
  assign aux1_out = (sel_in == 4'h4) ? sig_in : ~sig_in;
  assign aux2_out = (sel_in == 4'h5) ? sig_in : ~sig_in;
endmodule : sensor_front_end_model
